// File: src/pgr_pkg.sv
// Package for the power-good control, fault latch and soft reset bank.
// Assumes an 8-bit register port behind the serial host interface.
package pgr_pkg;

  // Number of monitored rails: buck a, buck b, linear 0, linear 1.
  localparam int unsigned PGR_RAILS = 4;

  // Register addresses.
  localparam logic [7:0] PGR_ADDR_CTRL1 = 8'h15;
  localparam logic [7:0] PGR_ADDR_CTRL2 = 8'h16;
  localparam logic [7:0] PGR_ADDR_FAULT = 8'h17;
  localparam logic [7:0] PGR_ADDR_RESET = 8'h18;
  localparam logic [7:0] PGR_ADDR_INT1  = 8'h19;
  localparam logic [7:0] PGR_ADDR_INT2  = 8'h1a;

  // First control register fields.
  localparam int unsigned PGR_C1_POL    = 7;
  localparam int unsigned PGR_C1_OD     = 6;
  localparam int unsigned PGR_C1_EN_LSB = 0;

  // Second control register fields.
  localparam int unsigned PGR_C2_TWARN = 2;
  localparam int unsigned PGR_C2_GATE  = 1;
  localparam int unsigned PGR_C2_MODE  = 0;
  localparam int unsigned PGR_C2_W     = 3;

  // Fault latch bit per rail.
  localparam int unsigned PGR_F_BUCK_A = 0;
  localparam int unsigned PGR_F_BUCK_B = 1;
  localparam int unsigned PGR_F_LIN0   = 2;
  localparam int unsigned PGR_F_LIN1   = 3;

  // Command and interrupt bits.
  localparam int unsigned PGR_RST_CMD  = 0;
  localparam int unsigned PGR_INT1_PG  = 7;
  localparam int unsigned PGR_INT2_RST = 0;

  // Values after reset.
  localparam logic [7:0]          PGR_CTRL1_RST = 8'h00;
  localparam logic [PGR_C2_W-1:0] PGR_CTRL2_RST = 3'h0;
  localparam logic [3:0]          PGR_FAULT_RST = 4'h0;

  // Reset and reload sequence.
  typedef enum logic [1:0] {
    PGR_SEQ_CLEAR,
    PGR_SEQ_LOAD,
    PGR_SEQ_RUN
  } pgr_seq_e;

endpackage : pgr_pkg

// File: src/pgr_rail_if.sv
// Interface carrying rail status between the bank and the rail evaluator.
// Assumes all members are on the same clock as the register bank.
`timescale 1ns/1ps
interface pgr_rail_if #(
  parameter int unsigned RAILS = 4
);
  logic [RAILS-1:0] en;          // Rail monitored for power-good.
  logic [RAILS-1:0] valid;       // Synchronised live rail validity.
  logic [RAILS-1:0] started;     // Synchronised start-up done per rail.
  logic             cont_mode;   // Continuous mode selected.
  logic             run;         // Bank is out of its reset sequence.
  logic [RAILS-1:0] fail;        // Monitored rail invalid while evaluated.
  logic             live_good;   // All monitored rails valid.
  logic             window_open; // Evaluation not masked by gating.

  modport ctl  (output en, valid, started, cont_mode, run,
                input  fail, live_good, window_open);
  modport eval (input  en, valid, started, cont_mode, run,
                output fail, live_good, window_open);
endinterface : pgr_rail_if

// File: src/pgr_rail_eval.sv
// Rail evaluator: turns rail validity and enables into fault and good terms.
// Assumes its inputs are already synchronised to the bank clock.
`timescale 1ns/1ps
module pgr_rail_eval
  import pgr_pkg::*;
(
  // Rail status from and to the bank
  pgr_rail_if.eval rail
);

  // gated masking window
  // Gated mode holds evaluation off until every monitored rail has come
  // up, so a slow start-up never latches a false fault.
  assign rail.window_open = rail.run &
                            (rail.cont_mode | (&(rail.started | ~rail.en)));

  assign rail.live_good = &(rail.valid | ~rail.en);

  assign rail.fail = rail.en & ~rail.valid &
                     {$bits(rail.fail){rail.window_open}};

endmodule : pgr_rail_eval

// File: src/pgr_bank.sv
// Power-good control, per-rail fault latches and soft reset command bank.
// Assumes a register port already decoded from the serial host interface,
// analog rail and thermal flags arriving asynchronously, and an OTP
// reader that reports completion after a reload request.
`timescale 1ns/1ps
module pgr_bank
  import pgr_pkg::*;
#(
  parameter int unsigned RAILS = PGR_RAILS
)(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Register port
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  output logic      [7:0]       rdata_o,
  output logic                  rvalid_o,
  // Analog status flags, asynchronous
  input  wire logic [RAILS-1:0] rail_valid_i,
  input  wire logic [RAILS-1:0] rail_started_i,
  input  wire logic             thermal_warn_i,
  // OTP reload
  input  wire logic [7:0]       otp_ctrl1_i,
  input  wire logic [2:0]       otp_ctrl2_i,
  input  wire logic             otp_done_i,
  output logic                  otp_reload_o,
  // Serial interface reset
  output logic                  i2c_reset_o,
  // Power-good pin
  output logic                  power_good_out_o,
  output logic                  power_good_out_oe_o
);

  // The bank's field layout is fixed at four rails.
  if (RAILS != PGR_RAILS) begin : g_bad_rails
    $error("pgr_bank supports exactly four rails");
  end

  localparam int unsigned SW = 2 * RAILS + 1;

  pgr_rail_if #(.RAILS(RAILS)) rail ();

  pgr_seq_e            state_q, state_d;
  logic [SW-1:0]       sync1_q, sync2_q;
  logic [7:0]          ctrl1_q;
  logic [PGR_C2_W-1:0] ctrl2_q;
  logic [RAILS-1:0]    fault_q, fault_d;
  logic                cmd_q, pg_int_q, rst_int_q, good_q;
  logic                pg_lvl_q, pg_oe_q;
  logic [7:0]          rdata_q;
  logic                rvalid_q;

  // Two-stage synchroniser for every analog flag; only stage two is read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {thermal_warn_i, rail_started_i, rail_valid_i};
      sync2_q <= sync1_q;
    end
  end

  wire logic [RAILS-1:0] valid_s   = sync2_q[RAILS-1:0];
  wire logic [RAILS-1:0] started_s = sync2_q[2*RAILS-1:RAILS];
  wire logic             twarn_s   = sync2_q[SW-1];

  // Rail evaluator hookup.
  assign rail.en        = ctrl1_q[PGR_C1_EN_LSB +: RAILS];
  assign rail.valid     = valid_s;
  assign rail.started   = started_s;
  assign rail.cont_mode = ctrl2_q[PGR_C2_MODE];
  assign rail.run       = (state_q == PGR_SEQ_RUN);

  pgr_rail_eval u_eval (
    .rail (rail)
  );

  // Write decode; writes during the reset sequence are dropped because
  // the registers are being rebuilt from OTP at that time.
  wire logic wr_ok    = wr_i & rail.run;
  wire logic wr_ctrl1 = wr_ok & (addr_i == PGR_ADDR_CTRL1);
  wire logic wr_ctrl2 = wr_ok & (addr_i == PGR_ADDR_CTRL2);
  wire logic wr_fault = wr_ok & (addr_i == PGR_ADDR_FAULT);
  wire logic wr_reset = wr_ok & (addr_i == PGR_ADDR_RESET);
  wire logic wr_int1  = wr_ok & (addr_i == PGR_ADDR_INT1);
  wire logic wr_int2  = wr_ok & (addr_i == PGR_ADDR_INT2);

  wire logic soft_req = wr_reset & wdata_i[PGR_RST_CMD];

  // Power-good evaluation.
  // live or latched-fault source
  wire logic src_good   = ctrl2_q[PGR_C2_GATE] ? ~(|fault_q)
                                               : rail.live_good;
  wire logic twarn_kill = ctrl2_q[PGR_C2_TWARN] & twarn_s;
  wire logic good_d     = rail.window_open & src_good & ~twarn_kill;
  wire logic pg_lvl_d   = good_d ^ ctrl1_q[PGR_C1_POL];

  // Fault latches: a new fault wins over a clear in the same cycle.
  // clear only while valid
  wire logic [RAILS-1:0] clr_ok = {RAILS{wr_fault}} &
                                  wdata_i[RAILS-1:0] & valid_s;
  assign fault_d = (fault_q & ~clr_ok) | rail.fail;

  // Sequencer: clear registers, reload OTP, then run.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PGR_SEQ_CLEAR: state_d = PGR_SEQ_LOAD;
      PGR_SEQ_LOAD:  if (otp_done_i) state_d = PGR_SEQ_RUN;
      PGR_SEQ_RUN:   if (cmd_q) state_d = PGR_SEQ_CLEAR;
      default:       state_d = PGR_SEQ_CLEAR;
    endcase
  end

  assign otp_reload_o = (state_q == PGR_SEQ_CLEAR);
  assign i2c_reset_o  = (state_q == PGR_SEQ_CLEAR);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= PGR_SEQ_CLEAR;
    end else begin
      state_q <= state_d;
    end
  end

  // Control registers; the OTP image is taken once the reload finishes.
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q == PGR_SEQ_CLEAR) begin
      ctrl1_q <= PGR_CTRL1_RST;
      ctrl2_q <= PGR_CTRL2_RST;
    end else if (state_q == PGR_SEQ_LOAD && otp_done_i) begin
      ctrl1_q <= otp_ctrl1_i;
      ctrl2_q <= otp_ctrl2_i;
    end else begin
      if (wr_ctrl1) ctrl1_q <= wdata_i;
      if (wr_ctrl2) ctrl2_q <= wdata_i[PGR_C2_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q == PGR_SEQ_CLEAR) begin
      fault_q <= PGR_FAULT_RST;
    end else begin
      fault_q <= fault_d;
    end
  end

  // command self-clears
  // The bit stands one cycle, then the sequencer has taken it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= 1'b0;
    end else begin
      cmd_q <= soft_req;
    end
  end

  // Interrupt flags; set wins over a write-one clear.
  // reset-occurred flag
  // The soft reset sets this flag so software can see why it restarted.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_int_q <= 1'b0;
      pg_int_q  <= 1'b0;
      good_q    <= 1'b0;
    end else begin
      good_q <= good_d;
      if (state_q == PGR_SEQ_CLEAR) begin
        rst_int_q <= 1'b1;
        pg_int_q  <= 1'b0;
      end else begin
        if (wr_int2 && wdata_i[PGR_INT2_RST]) rst_int_q <= 1'b0;
        if (good_q && !good_d) begin
          pg_int_q <= 1'b1;
        end else if (wr_int1 && wdata_i[PGR_INT1_PG]) begin
          pg_int_q <= 1'b0;
        end
      end
    end
  end

  // Pin driver: push-pull drives both levels, open-drain only pulls low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pg_lvl_q <= 1'b0;
      pg_oe_q  <= 1'b0;
    end else begin
      pg_lvl_q <= ctrl1_q[PGR_C1_OD] ? 1'b0 : pg_lvl_d;
      pg_oe_q  <= ctrl1_q[PGR_C1_OD] ? ~pg_lvl_d : 1'b1;
    end
  end

  assign power_good_out_o    = pg_lvl_q;
  assign power_good_out_oe_o = pg_oe_q;

  // Read mux; unmapped addresses and reserved bits read as zero, except ctrl1 bits 5:4, which read as written.
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    if (addr_i == PGR_ADDR_CTRL1) begin
      rmux = ctrl1_q;
    end else if (addr_i == PGR_ADDR_CTRL2) begin
      rmux[PGR_C2_W-1:0] = ctrl2_q;
    end else if (addr_i == PGR_ADDR_FAULT) begin
      rmux[RAILS-1:0] = fault_q;
    end else if (addr_i == PGR_ADDR_RESET) begin
      rmux[PGR_RST_CMD] = cmd_q;
    end else if (addr_i == PGR_ADDR_INT1) begin
      rmux[PGR_INT1_PG] = pg_int_q;
    end else if (addr_i == PGR_ADDR_INT2) begin
      rmux[PGR_INT2_RST] = rst_int_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_i;
      if (rd_i) rdata_q <= rmux;
    end
  end

  assign rdata_o  = rdata_q;
  assign rvalid_o = rvalid_q;

endmodule : pgr_bank

// File: sim/pgr_otp_model.sv
// OTP reader model answering reload requests from the register bank.
// Assumes the bank pulses reload_i once and waits for done_o.
`timescale 1ns/1ps
module pgr_otp_model #(
  parameter logic [7:0]  IMG1  = 8'h0f,
  parameter logic [2:0]  IMG2  = 3'h1,
  parameter int unsigned DELAY = 6
)(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Reload handshake and images
  input  wire logic       reload_i,
  output logic            done_o,
  output logic      [7:0] ctrl1_o,
  output logic      [2:0] ctrl2_o
);
  logic [3:0] cnt_q;

  // Images stay put; only the completion flag moves.
  assign ctrl1_o = IMG1;
  assign ctrl2_o = IMG2;

  // slow memory read
  // A new request drops done at once, so a stale done never ends a reload.
  always_ff @(posedge clk_i) begin
    if (rst_i || reload_i) begin
      cnt_q  <= 4'(DELAY);
      done_o <= 1'b0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      done_o <= 1'b1;
    end
  end
endmodule : pgr_otp_model

// File: sim/pgr_bank_checker.sv
// Port checker for the power-good register bank.
// Assumes the OTP reader drops done when a reload is requested.
`timescale 1ns/1ps
module pgr_bank_checker
  import pgr_pkg::*;
#(
  parameter int unsigned RAILS = PGR_RAILS
)(
  // Clock, reset and register port
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rvalid_o,
  // Reload and pin
  input wire logic       otp_done_i,
  input wire logic       otp_reload_o,
  input wire logic       i2c_reset_o,
  input wire logic       power_good_out_o,
  input wire logic       power_good_out_oe_o
);
  logic run_q;
  logic arm_q;
  wire  cmd = wr_i && addr_i == PGR_ADDR_RESET && wdata_i[0] && run_q;

  // Track run state and whether a reload has a cause pending.
  always_ff @(posedge clk_i) begin
    run_q <= (rst_i || otp_reload_o) ? 1'b0 : (run_q | otp_done_i);
    arm_q <= (rst_i || cmd) ? 1'b1 : (arm_q & ~otp_reload_o);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_read;
    rd_i ##1 rvalid_o;
  endsequence
  sequence s_cmd;
    cmd;
  endsequence

  AST_READ_ANSWER: assert property (rd_i |-> s_read)
    else $error("read not answered next cycle");
  AST_NO_STRAY_VALID: assert property (!rd_i |=> !rvalid_o)
    else $error("read valid without a read");
  AST_RDATA_HOLD: assert property (!rvalid_o |-> $stable(rdata_o))
    else $error("read data moved without a read");
  AST_SERIAL_RESET: assert property (i2c_reset_o == otp_reload_o)
    else $error("serial reset differs from reload");
  AST_RELOAD_ONCE: assert property (otp_reload_o |=> !otp_reload_o [*4])
    else $error("reload pulse repeated");
  AST_SOFT_RESET: assert property (s_cmd |-> ##[1:3] otp_reload_o)
    else $error("soft reset gave no reload");
  AST_RELOAD_CAUSE: assert property (otp_reload_o |-> arm_q)
    else $error("reload without cause");
  AST_PIN_DEFAULT: assert property (otp_reload_o |->
    ##[2:4] (!power_good_out_o && power_good_out_oe_o))
    else $error("pin not inactive during reload");
endmodule : pgr_bank_checker

bind pgr_bank pgr_bank_checker #(.RAILS(RAILS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .otp_done_i(otp_done_i),
  .otp_reload_o(otp_reload_o), .i2c_reset_o(i2c_reset_o),
  .power_good_out_o(power_good_out_o),
  .power_good_out_oe_o(power_good_out_oe_o));

// File: sim/tb.sv
// Testbench for the power-good register bank.
// Assumes the OTP model loads ctrl1 0x0f and ctrl2 0x1 after each reload.
`timescale 1ns/1ps
module tb;
  import pgr_pkg::*;
  logic       clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, twarn = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, c1;
  logic [3:0] valid = 4'hf, started = 4'hf;
  logic [2:0] c2;
  logic       rvalid, done, reload, pg, pg_oe;
  int         failures = 0, tests_run = 0;

  pgr_bank DUT (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
    .rail_valid_i(valid), .rail_started_i(started), .thermal_warn_i(twarn),
    .otp_ctrl1_i(c1), .otp_ctrl2_i(c2), .otp_done_i(done),
    .otp_reload_o(reload), .i2c_reset_o(),
    .power_good_out_o(pg), .power_good_out_oe_o(pg_oe));
  pgr_otp_model u_otp (.clk_i(clk_i), .rst_i(rst_i), .reload_i(reload),
    .done_o(done), .ctrl1_o(c1), .ctrl2_o(c2));

  // Clock of 4 ns.
  always #2 clk_i = ~clk_i;

  task automatic chk(input string n, input logic [8:0] s, e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // callers keep reserved bits at zero.
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    wr_i  <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", {rvalid, rdata}, {1'b1, e});
    // Hand back on an edge so that callers drive inputs on the rising edge.
    @(posedge clk_i);
  endtask : rd

  // Level follows good; the enable stays high unless open-drain releases.
  task automatic pin(input logic e, input logic oe = 1'b1);
    repeat (5) @(posedge clk_i);
    #1;
    chk("pin", {7'h0, pg_oe, pg}, {7'h0, oe, e});
    @(posedge clk_i);
  endtask : pin

  task automatic test_done;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rd(PGR_ADDR_CTRL2, 8'h01);
    rd(PGR_ADDR_FAULT, 8'h00);
    rd(PGR_ADDR_RESET, 8'h00);
    rd(8'h40, 8'h00);
    pin(1'b1);
    twarn <= 1'b1;
    pin(1'b1);
    wr(PGR_ADDR_CTRL2, 8'h05);
    pin(1'b0);
    twarn <= 1'b0;
    wr(PGR_ADDR_CTRL2, 8'h01);
    for (int i = 0; i < 4; i++) begin
      valid[i] <= 1'b0;
      pin(1'b0);
      wr(PGR_ADDR_FAULT, 8'h0f);
      rd(PGR_ADDR_FAULT, 8'(1 << i));
      valid[i] <= 1'b1;
      pin(1'b1);
      wr(PGR_ADDR_FAULT, 8'h00);
      wr(PGR_ADDR_CTRL2, 8'h03);
      pin(1'b0);
      rd(PGR_ADDR_FAULT, 8'(1 << i));
      wr(PGR_ADDR_FAULT, 8'(1 << i));
      rd(PGR_ADDR_FAULT, 8'h00);
      pin(1'b1);
      wr(PGR_ADDR_CTRL2, 8'h01);
    end
    wr(PGR_ADDR_CTRL1, 8'h07);
    valid[3] <= 1'b0;
    pin(1'b1);
    rd(PGR_ADDR_FAULT, 8'h00);
    valid[3] <= 1'b1;
    started[0] <= 1'b0;
    pin(1'b1);
    wr(PGR_ADDR_CTRL2, 8'h00);
    pin(1'b0);
    started[0] <= 1'b1;
    pin(1'b1);
    wr(PGR_ADDR_CTRL1, 8'h8f);
    pin(1'b0);
    // Open-drain: a low level pulls low, a high one releases.
    wr(PGR_ADDR_CTRL1, 8'hcf);
    pin(1'b0, 1'b1);
    wr(PGR_ADDR_CTRL1, 8'h4f);
    pin(1'b0, 1'b0);
    wr(PGR_ADDR_RESET, 8'h01);
    repeat (20) @(posedge clk_i);
    rd(PGR_ADDR_RESET, 8'h00);
    rd(PGR_ADDR_INT2, 8'h01);
    rd(PGR_ADDR_CTRL1, 8'h0f);
    wr(PGR_ADDR_INT2, 8'h01);
    rd(PGR_ADDR_INT2, 8'h00);
    test_done();
  end

  // Watchdog well beyond the expected run of about 330 cycles.
  initial begin
    #40000;
    failures++;
    test_done();
  end
endmodule : tb
